/* File: video_pin_defs.svh */
`ifndef VIDEO_PIN_DEFS_SVH
`define VIDEO_PIN_DEFS_SVH

// --------
// host i/o ports: index port and data port
// --------
`define IO_INDEX_PORT 16'h03D6
`define IO_DATA_PORT 16'h03D7

// --------
// register indexes
// --------
`define IDX_VIDEO_PIN_CONTROL 8'h60
`define IDX_SYNC_PIN_SELECT 8'h61
`define IDX_GP_PIN_DIRECTION 8'h62
`define IDX_GP_PIN_DATA 8'h63
`define IDX_PIN_FLOAT_CONTROL 8'h67
`define IDX_STRAP_LATCH_LOW 8'h70
`define IDX_STRAP_LATCH_HIGH 8'h71

// --------
// video pin control fields
// --------
`define VPC_CLK_HALF_BIT 6
`define VPC_BLANK_POL_BIT 5
`define VPC_BLANK_SRC_BIT 4
`define VPC_UPPER_OUT_BIT 3
`define VPC_LOWER_OUT_BIT 2
`define VPC_MODE_HI 1
`define VPC_MODE_LO 0

// --------
// sync pin select fields
// --------
`define SPS_V_PSEQ_BIT 6
`define SPS_H_PSEQ_BIT 5
`define SPS_DRIVE_LOWPWR_BIT 4
`define SPS_V_CTL_BIT 3
`define SPS_V_DATA_BIT 2
`define SPS_H_CTL_BIT 1
`define SPS_H_DATA_BIT 0

// --------
// general purpose and float control fields
// --------
`define GP_CLK_BIT 3
`define GP_DATA_BIT 2
`define PFC_CLAIM_DRIVE_BIT 2
`define PFC_VIDEO_FLOAT_BIT 1
`define PFC_MEM_FLOAT_BIT 0

// --------
// strap bit positions in the low strap register
// --------
`define STRAP_CLKTEST_BIT 7
`define STRAP_ACTIVITY_INDICATOR_OUT_BIT 6
`define STRAP_EXTCLK_BIT 4
`define STRAP_VGADEC_BIT 1

// --------
// reset values
// --------
`define RST_CTL7 7'h00
`define RST_CTL3 3'h0
`define RST_GP_DIR 2'h0
`define RST_GP_DATA 4'h0
`define RST_BYTE 8'h00
`define RST_STRAP_LOW 8'h01

`endif

/* File: video_pin_pkg.sv */
package video_pin_pkg;

    // ----------------------------------------------------------------
    // connector behaviour modes
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        CONN_DISABLED = 2'h0,
        CONN_STD_FEATURE = 2'h1,
        CONN_ADV_FEATURE = 2'h2,
        CONN_ZOOMED = 2'h3
    } connector_mode_t;

    // strap capture phase, gray along the path
    typedef enum logic [1:0] {
        STRAP_WAIT = 2'h0,
        STRAP_HELD = 2'h1
    } strap_phase_t;

    // ----------------------------------------------------------------
    // state records
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] index_ff;
        logic [6:0] video_ctl_ff;
        logic [6:0] sync_ctl_ff;
        logic [1:0] gp_dir_ff;
        logic [3:0] gp_data_ff;
        logic [2:0] float_ctl_ff;
        logic [7:0] strap_lo_ff;
        logic [7:0] strap_hi_ff;
        strap_phase_t phase_ff;
        logic [7:0] rdata_ff;
    } pin_ctrl_state_t;

    typedef struct packed {
        logic pin_ff;
        logic oe_ff;
    } sync_drv_state_t;

    typedef struct packed {
        logic prev_ff;
        logic half_ff;
    } clk_div_state_t;

endpackage : video_pin_pkg

/* File: sync_pin_driver.sv */
// one sync pin: power sequencing clock, override data or normal sync
module sync_pin_driver
(
    input wire logic clk,
    input wire logic rst,
    input wire logic normal_sync,
    input wire logic pseq_clock,
    input wire logic pseq_sel,
    input wire logic override_en,
    input wire logic override_data,
    input wire logic low_power,
    input wire logic drive_low_power,
    output logic pin_out,
    output logic pin_oe
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    video_pin_pkg::sync_drv_state_t st_ff; // registered pin drive
    video_pin_pkg::sync_drv_state_t nxt_st; // next pin drive

    // pick the pin source and decide whether it floats
    always_comb
    begin
        nxt_st = st_ff;
        if (pseq_sel)
        begin
            nxt_st.pin_ff = pseq_clock;
        end
        else if (override_en)
        begin
            nxt_st.pin_ff = override_data;
        end
        else
        begin
            nxt_st.pin_ff = normal_sync; // normal sync
        end
        nxt_st.oe_ff = !low_power || drive_low_power;
    end

    // register the copy
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign pin_out = st_ff.pin_ff;
    assign pin_oe = st_ff.oe_ff;

endmodule : sync_pin_driver

/* File: pixel_clock_divider.sv */
// halves a sampled dot clock level by toggling on its rising edges
module pixel_clock_divider
(
    input wire logic clk,
    input wire logic rst,
    input wire logic dot_clock,
    output logic half_clock
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    video_pin_pkg::clk_div_state_t st_ff; // previous level and divided clock
    video_pin_pkg::clk_div_state_t nxt_st; // next divider state

    // toggle on each rising edge of the sampled dot clock
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.prev_ff = dot_clock;
        if (dot_clock && !st_ff.prev_ff)
        begin
            nxt_st.half_ff = !st_ff.half_ff;
        end
    end

    // register the copy
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign half_clock = st_ff.half_ff;

endmodule : pixel_clock_divider

/* File: video_pin_and_strap_control.sv */
`include "video_pin_defs.svh"

module video_pin_and_strap_control
(
    input wire logic clk,
    input wire logic rst,
    // host indexed i/o port
    input wire logic [15:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    // clocks, video timing and power modes from the core
    input wire logic dot_clock,
    input wire logic vclk_synth,
    input wire logic mclk_synth,
    input wire logic y_enable,
    input wire logic display_enable,
    input wire logic normal_hsync,
    input wire logic normal_vsync,
    input wire logic pseq_clock,
    input wire logic standby_mode,
    input wire logic panel_off_mode,
    input wire logic suspend_mode,
    // video port pins
    output logic video_port_clock_out,
    output logic video_port_clock_oe,
    output logic blank_out,
    output logic blank_oe,
    output logic pixel_port_upper_byte_oe,
    output logic pixel_port_lower_byte_oe,
    output video_pin_pkg::connector_mode_t connector_mode,
    // sync pins
    output logic hsync_out,
    output logic hsync_oe,
    output logic vsync_out,
    output logic vsync_oe,
    // display channel and general purpose pins
    input wire logic display_channel_clock_pin_in,
    output logic display_channel_clock_pin_out,
    output logic display_channel_clock_pin_oe,
    input wire logic display_channel_data_pin_in,
    output logic display_channel_data_pin_out,
    output logic display_channel_data_pin_oe,
    output logic [1:0] gp_pin_out,
    // claim, indicator and rom pins
    input wire logic local_device_claim_in,
    output logic local_device_claim_out,
    output logic local_device_claim_oe,
    input wire logic activity_in,
    input wire logic backlight_in,
    output logic activity_indicator_out,
    output logic activity_indicator_oe,
    output logic backlight_enable_out,
    output logic backlight_enable_oe,
    input wire logic rom_output_enable_in_n,
    output logic rom_output_enable_pin_n,
    // memory interface and strap pins
    input wire logic [9:0] strap_addr_in,
    input wire logic [7:0] strap_data_in,
    output logic mem_pins_oe,
    // strap driven configuration
    output logic use_external_clocks,
    output logic reference_clock_pin_oe,
    output logic test_clock_pin_oe,
    output logic vga_io_decode_en,
    output logic [1:0] config_reg_bits
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------

    // true when the host address hits the given port
    function automatic logic is_port(input logic [15:0] addr, input logic [15:0] port);
        is_port = (addr == port);
    endfunction : is_port

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    video_pin_pkg::pin_ctrl_state_t st_ff; // all registers of this block
    video_pin_pkg::pin_ctrl_state_t nxt_st; // next value of all registers
    logic data_hit; // host touches the data port
    logic index_hit; // host touches the index port
    logic [7:0] gp_data_view; // data register as software sees it
    logic [7:0] rd_value; // value selected by the index
    logic straps_held; // strap capture done, pins may drive
    logic clock_test; // clock test mode from straps
    logic half_clock; // divided dot clock
    logic blank_src; // selected blank source
    logic v_pin; // vsync driver output
    logic v_oe; // vsync driver enable
    logic h_pin; // hsync driver output
    logic h_oe; // hsync driver enable
    logic low_power; // standby or panel off
    logic video_float; // video port forced off

    // ----------------------------------------------------------------
    // host decode
    // ----------------------------------------------------------------

    assign data_hit = is_port(io_addr, `IO_DATA_PORT);
    assign index_hit = is_port(io_addr, `IO_INDEX_PORT);

    // input pins read back while their direction is input
    always_comb
    begin
        gp_data_view = 8'h00;
        gp_data_view[`GP_CLK_BIT] = st_ff.gp_dir_ff[1] ? st_ff.gp_data_ff[`GP_CLK_BIT]
                                                      : display_channel_clock_pin_in;
        gp_data_view[`GP_DATA_BIT] = st_ff.gp_dir_ff[0] ? st_ff.gp_data_ff[`GP_DATA_BIT]
                                                       : display_channel_data_pin_in;
        gp_data_view[1:0] = st_ff.gp_data_ff[1:0];
    end

    // read multiplexer over the indexed registers
    always_comb
    begin
        rd_value = 8'h00;
        case (st_ff.index_ff)
            `IDX_VIDEO_PIN_CONTROL:
            begin
                rd_value = {1'b0, st_ff.video_ctl_ff};
            end
            `IDX_SYNC_PIN_SELECT:
            begin
                rd_value = {1'b0, st_ff.sync_ctl_ff};
            end
            `IDX_GP_PIN_DIRECTION:
            begin
                rd_value = {4'h0, st_ff.gp_dir_ff, 2'h0};
            end
            `IDX_GP_PIN_DATA:
            begin
                rd_value = gp_data_view;
            end
            `IDX_PIN_FLOAT_CONTROL:
            begin
                rd_value = {5'h00, st_ff.float_ctl_ff};
            end
            `IDX_STRAP_LATCH_LOW:
            begin
                rd_value = {st_ff.strap_lo_ff[7:1], 1'b1};
            end
            `IDX_STRAP_LATCH_HIGH:
            begin
                rd_value = st_ff.strap_hi_ff;
            end
            default:
            begin
                rd_value = 8'h00; // unmapped index reads zero
            end
        endcase
    end

    // ----------------------------------------------------------------
    // register updates and strap capture
    // ----------------------------------------------------------------

    // writes, read capture and the one-time strap latch
    always_comb
    begin
        nxt_st = st_ff;
        // index port write
        if (io_wr && index_hit)
        begin
            nxt_st.index_ff = io_wdata;
        end
        // data port write, reserved bits dropped
        if (io_wr && data_hit)
        begin
            case (st_ff.index_ff)
                `IDX_VIDEO_PIN_CONTROL:
                begin
                    nxt_st.video_ctl_ff = io_wdata[6:0];
                end
                `IDX_SYNC_PIN_SELECT:
                begin
                    nxt_st.sync_ctl_ff = io_wdata[6:0];
                end
                `IDX_GP_PIN_DIRECTION:
                begin
                    nxt_st.gp_dir_ff = io_wdata[3:2];
                end
                `IDX_GP_PIN_DATA:
                begin
                    nxt_st.gp_data_ff = io_wdata[3:0];
                end
                `IDX_PIN_FLOAT_CONTROL:
                begin
                    nxt_st.float_ctl_ff = io_wdata[2:0];
                end
                default:
                begin
                    nxt_st.index_ff = st_ff.index_ff; // read-only or unmapped: ignored
                end
            endcase
        end
        // read data held in a flop
        if (io_rd)
        begin
            if (data_hit)
            begin
                nxt_st.rdata_ff = rd_value;
            end
            else if (index_hit)
            begin
                nxt_st.rdata_ff = st_ff.index_ff;
            end
            else
            begin
                nxt_st.rdata_ff = 8'h00;
            end
        end
        // straps caught on the first edge after reset release
        case (st_ff.phase_ff)
            video_pin_pkg::STRAP_WAIT:
            begin
                nxt_st.strap_lo_ff = {strap_addr_in[7:1], 1'b1};
                nxt_st.strap_hi_ff = {strap_data_in[7:2], strap_addr_in[9:8]};
                nxt_st.phase_ff = video_pin_pkg::STRAP_HELD;
            end
            video_pin_pkg::STRAP_HELD:
            begin
                nxt_st.phase_ff = video_pin_pkg::STRAP_HELD; // latched for good
            end
            default:
            begin
                nxt_st.phase_ff = video_pin_pkg::STRAP_WAIT;
            end
        endcase
    end

    // register the copy
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st_ff.index_ff <= `RST_BYTE;
            st_ff.video_ctl_ff <= `RST_CTL7;
            st_ff.sync_ctl_ff <= `RST_CTL7;
            st_ff.gp_dir_ff <= `RST_GP_DIR;
            st_ff.gp_data_ff <= `RST_GP_DATA;
            st_ff.float_ctl_ff <= `RST_CTL3;
            st_ff.strap_lo_ff <= `RST_STRAP_LOW;
            st_ff.strap_hi_ff <= `RST_BYTE;
            st_ff.phase_ff <= video_pin_pkg::STRAP_WAIT;
            st_ff.rdata_ff <= `RST_BYTE;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign io_rdata = st_ff.rdata_ff;

    // ----------------------------------------------------------------
    // strap effects
    // ----------------------------------------------------------------

    assign straps_held = (st_ff.phase_ff == video_pin_pkg::STRAP_HELD);
    assign clock_test = straps_held && !st_ff.strap_lo_ff[`STRAP_CLKTEST_BIT];
    assign use_external_clocks = straps_held && !st_ff.strap_lo_ff[`STRAP_EXTCLK_BIT];
    assign reference_clock_pin_oe = straps_held && st_ff.strap_lo_ff[`STRAP_EXTCLK_BIT];
    assign test_clock_pin_oe = straps_held && st_ff.strap_lo_ff[`STRAP_EXTCLK_BIT];
    assign vga_io_decode_en = straps_held && st_ff.strap_lo_ff[`STRAP_VGADEC_BIT];
    assign config_reg_bits = {vga_io_decode_en, 1'b1};

    // memory pins stay undriven until straps are caught
    assign mem_pins_oe = straps_held && !st_ff.float_ctl_ff[`PFC_MEM_FLOAT_BIT];

    // indicator outputs floated by a low strap
    assign activity_indicator_out = activity_in;
    assign backlight_enable_out = backlight_in;
    assign activity_indicator_oe = straps_held && st_ff.strap_lo_ff[`STRAP_ACTIVITY_INDICATOR_OUT_BIT];
    assign backlight_enable_oe = straps_held && st_ff.strap_lo_ff[`STRAP_ACTIVITY_INDICATOR_OUT_BIT];

    // rom enable carries the memory synthesizer in clock test
    assign rom_output_enable_pin_n = clock_test ? mclk_synth : rom_output_enable_in_n;

    // ----------------------------------------------------------------
    // video port pins
    // ----------------------------------------------------------------

    pixel_clock_divider u_div
    (
        .clk(clk),
        .rst(rst),
        .dot_clock(dot_clock),
        .half_clock(half_clock)
    );

    assign video_float = st_ff.float_ctl_ff[`PFC_VIDEO_FLOAT_BIT];

    // clock pin: test synthesizer, half or full dot clock
    always_comb
    begin
        if (clock_test)
        begin
            video_port_clock_out = vclk_synth;
        end
        else if (st_ff.video_ctl_ff[`VPC_CLK_HALF_BIT])
        begin
            video_port_clock_out = half_clock;
        end
        else
        begin
            video_port_clock_out = dot_clock;
        end
    end

    // blank pin source and polarity
    assign blank_src = st_ff.video_ctl_ff[`VPC_BLANK_SRC_BIT] ? display_enable : y_enable;
    assign blank_out = st_ff.video_ctl_ff[`VPC_BLANK_POL_BIT] ? !blank_src : blank_src;

    // enables of the video port pins
    assign video_port_clock_oe = !video_float;
    assign blank_oe = !video_float;
    assign pixel_port_upper_byte_oe = st_ff.video_ctl_ff[`VPC_UPPER_OUT_BIT] && !video_float;
    assign pixel_port_lower_byte_oe = st_ff.video_ctl_ff[`VPC_LOWER_OUT_BIT] && !video_float;
    assign connector_mode =
        video_pin_pkg::connector_mode_t'(st_ff.video_ctl_ff[`VPC_MODE_HI:`VPC_MODE_LO]);

    // ----------------------------------------------------------------
    // sync pins
    // ----------------------------------------------------------------

    assign low_power = standby_mode || panel_off_mode;

    sync_pin_driver u_vsync
    (
        .clk(clk),
        .rst(rst),
        .normal_sync(normal_vsync),
        .pseq_clock(pseq_clock),
        .pseq_sel(st_ff.sync_ctl_ff[`SPS_V_PSEQ_BIT]),
        .override_en(st_ff.sync_ctl_ff[`SPS_V_CTL_BIT]),
        .override_data(st_ff.sync_ctl_ff[`SPS_V_DATA_BIT]),
        .low_power(low_power),
        .drive_low_power(st_ff.sync_ctl_ff[`SPS_DRIVE_LOWPWR_BIT]),
        .pin_out(v_pin),
        .pin_oe(v_oe)
    );

    sync_pin_driver u_hsync
    (
        .clk(clk),
        .rst(rst),
        .normal_sync(normal_hsync),
        .pseq_clock(pseq_clock),
        .pseq_sel(st_ff.sync_ctl_ff[`SPS_H_PSEQ_BIT]),
        .override_en(st_ff.sync_ctl_ff[`SPS_H_CTL_BIT]),
        .override_data(st_ff.sync_ctl_ff[`SPS_H_DATA_BIT]),
        .low_power(low_power),
        .drive_low_power(st_ff.sync_ctl_ff[`SPS_DRIVE_LOWPWR_BIT]),
        .pin_out(h_pin),
        .pin_oe(h_oe)
    );

    assign vsync_out = v_pin;
    assign hsync_out = h_pin;
    assign vsync_oe = v_oe;
    assign hsync_oe = h_oe;

    // ----------------------------------------------------------------
    // display channel, general purpose and claim pins
    // ----------------------------------------------------------------

    assign display_channel_clock_pin_out = st_ff.gp_data_ff[`GP_CLK_BIT];
    assign display_channel_data_pin_out = st_ff.gp_data_ff[`GP_DATA_BIT];
    assign display_channel_clock_pin_oe = st_ff.gp_dir_ff[1];
    assign display_channel_data_pin_oe = st_ff.gp_dir_ff[0];
    assign gp_pin_out = st_ff.gp_data_ff[1:0];

    // claim output floats in suspend unless software keeps it
    assign local_device_claim_out = local_device_claim_in;
    assign local_device_claim_oe = !suspend_mode || st_ff.float_ctl_ff[`PFC_CLAIM_DRIVE_BIT];

endmodule : video_pin_and_strap_control

/* File: video_pin_props.sv */
module video_pin_props
(
    input wire logic clk,
    input wire logic rst,
    input wire logic io_rd,
    input wire logic [7:0] io_rdata,
    input wire logic video_port_clock_oe,
    input wire logic blank_oe,
    input wire logic pixel_port_upper_byte_oe,
    input wire logic suspend_mode,
    input wire logic local_device_claim_oe,
    input wire logic use_external_clocks,
    input wire logic reference_clock_pin_oe,
    input wire logic [1:0] config_reg_bits
);
    timeunit 1ns;
    timeprecision 1ns;
    // --------
    // pin relations at the top ports
    // --------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    a_float_pair_same: assert property (video_port_clock_oe == blank_oe) else $error("enables split");
    a_pixel_byte_float: assert property (!blank_oe |-> !pixel_port_upper_byte_oe) else $error("byte on");
    a_claim_awake_on: assert property (!suspend_mode |-> local_device_claim_oe) else $error("claim off");
    a_ext_clock_in: assert property (use_external_clocks |-> !reference_clock_pin_oe) else $error("ref on");
    a_config_bit_one: assert property (config_reg_bits[0]) else $error("config low");
    a_decode_held_on: assert property ($rose(config_reg_bits[1]) |=> config_reg_bits[1] [*8])
        else $error("decode lost");
    a_ref_pin_held: assert property (reference_clock_pin_oe |=> reference_clock_pin_oe) else $error("ref lost");
    a_read_data_hold: assert property (!$past(io_rd) |-> $stable(io_rdata)) else $error("rdata moved");
endmodule : video_pin_props

/* File: strap_board_model.sv */
// board straps and the monitor's channel lines, both with pull-ups
module strap_board_model
(
    input wire logic alt,
    input wire logic mon_low,
    input wire logic display_channel_clock_pin_oe,
    input wire logic display_channel_clock_pin_out,
    input wire logic display_channel_data_pin_oe,
    input wire logic display_channel_data_pin_out,
    output logic dc_clk,
    output logic dc_dat,
    output logic [9:0] sa,
    output logic [7:0] sd
);
    timeunit 1ns;
    timeprecision 1ns;
    // two resistor fits; held steady across reset release
    assign sa = alt ? 10'h2A9 : 10'h156;
    assign sd = alt ? 8'h4B : 8'hB4;
    // released line floats high; monitor may pull data low
    assign dc_clk = display_channel_clock_pin_oe ? display_channel_clock_pin_out : 1'b1;
    assign dc_dat = (display_channel_data_pin_oe ? display_channel_data_pin_out : 1'b1) & !mon_low;
endmodule : strap_board_model

/* File: video_pin_and_strap_control_test.sv */
module video_pin_and_strap_control_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst, io_wr, io_rd, dot_clock, vclk_synth, mclk_synth, y_enable, display_enable, pseq_clock, alt;
    logic standby_mode, panel_off_mode, suspend_mode, activity_in, mon_low, dc_clk, dc_dat, blank_out, mem_pins_oe;
    logic [15:0] io_addr;
    logic [7:0] io_wdata, io_rdata, sd;
    logic [9:0] sa;
    logic [1:0] gp_pin_out;
    logic video_port_clock_out, pixel_port_upper_byte_oe, pixel_port_lower_byte_oe, hsync_out, vsync_out, vsync_oe;
    logic display_channel_clock_pin_out, display_channel_clock_pin_oe, display_channel_data_pin_out;
    logic display_channel_data_pin_oe, local_device_claim_oe, activity_indicator_oe, rom_output_enable_pin_n;
    logic use_external_clocks, vga_io_decode_en;
    video_pin_pkg::connector_mode_t connector_mode;
    int fails = 0, check_count = 0, cycles = 0;
    video_pin_and_strap_control video_pin_and_strap_control_inst (.clk, .rst, .io_addr, .io_wr, .io_rd, .io_wdata,
        .io_rdata, .dot_clock, .vclk_synth, .mclk_synth, .y_enable, .display_enable, .normal_hsync(1'b0),
        .normal_vsync(1'b0), .pseq_clock, .standby_mode, .panel_off_mode, .suspend_mode, .video_port_clock_out,
        .video_port_clock_oe(), .blank_out, .blank_oe(), .pixel_port_upper_byte_oe, .pixel_port_lower_byte_oe,
        .connector_mode, .hsync_out, .hsync_oe(), .vsync_out, .vsync_oe, .display_channel_clock_pin_in(dc_clk),
        .display_channel_clock_pin_out, .display_channel_clock_pin_oe, .display_channel_data_pin_in(dc_dat),
        .display_channel_data_pin_out, .display_channel_data_pin_oe, .gp_pin_out, .local_device_claim_in(1'b1),
        .local_device_claim_out(), .local_device_claim_oe, .activity_in, .backlight_in(1'b0),
        .activity_indicator_out(), .activity_indicator_oe, .backlight_enable_out(), .backlight_enable_oe(),
        .rom_output_enable_in_n(1'b1), .rom_output_enable_pin_n, .strap_addr_in(sa), .strap_data_in(sd),
        .mem_pins_oe, .use_external_clocks, .reference_clock_pin_oe(), .test_clock_pin_oe(), .vga_io_decode_en,
        .config_reg_bits());
    strap_board_model strap_board_model_inst (.alt, .mon_low, .display_channel_clock_pin_oe, .sa, .sd,
        .display_channel_clock_pin_out, .display_channel_data_pin_oe, .display_channel_data_pin_out, .dc_clk, .dc_dat);
    // --------
    // clock, hang guard, helpers
    // --------
    initial
    begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk)
        if (++cycles == 3000)
        begin
            fails++;
            summarize();
        end
    task summarize;
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : summarize
    task chk(input string n, input logic [7:0] s, input logic [7:0] e);
        check_count++;
        if (s !== e)
        begin
            fails++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    // index write, then data write or read, back to back
    task wr(input logic [7:0] i, input logic [7:0] d);
        @(negedge clk) {io_addr, io_wdata, io_wr} = {16'h03D6, i, 1'b1};
        @(negedge clk) {io_addr, io_wdata} = {16'h03D7, d};
        @(negedge clk) io_wr = 0;
    endtask : wr
    task rd(input logic [7:0] i, input logic [7:0] e);
        @(negedge clk) {io_addr, io_wdata, io_wr} = {16'h03D6, i, 1'b1};
        @(negedge clk) {io_addr, io_wr, io_rd} = {16'h03D7, 2'b01};
        @(negedge clk) io_rd = 0;
        chk("reg", io_rdata, e);
    endtask : rd
    // --------
    // scenarios
    // --------
    task t_straps(input logic b, input logic [7:0] lo, input logic [7:0] hi);
        alt = b;
        rst = 1;
        repeat (6) @(negedge clk);
        chk("mem oe", mem_pins_oe, 0);
        rst = 0;
        wr(8'h70, 8'h00);
        rd(8'h70, lo);
        rd(8'h71, hi);
        chk("strap", {activity_indicator_oe, use_external_clocks, vga_io_decode_en, mem_pins_oe}, {lo[6], !lo[4], lo[1], 1'b1});
        chk("clk test", {video_port_clock_out, rom_output_enable_pin_n}, {!lo[7], lo[7]});
    endtask : t_straps
    task t_video;
        for (int m = 0; m < 4; m++)
        begin
            wr(8'h60, 8'hF0 | m);
            chk("mode", connector_mode, m);
        end
        rd(8'h60, 8'h73);
        chk("blank", {blank_out, pixel_port_upper_byte_oe, pixel_port_lower_byte_oe}, 3'b100);
        wr(8'h5C, 8'h00);
        wr(8'h60, 8'h5C);
        chk("blank", {blank_out, pixel_port_upper_byte_oe, pixel_port_lower_byte_oe}, 3'b011);
        wr(8'h60, 8'h48);
        chk("blank", {blank_out, pixel_port_upper_byte_oe, pixel_port_lower_byte_oe}, 3'b110);
    endtask : t_video
    task t_float;
        wr(8'h67, 8'hFB);
        rd(8'h67, 8'h03);
        chk("float", {pixel_port_upper_byte_oe, mem_pins_oe, local_device_claim_oe}, 3'b001);
        suspend_mode = 1;
        @(negedge clk) chk("claim", local_device_claim_oe, 0);
        wr(8'h67, 8'h04);
        chk("float", {pixel_port_upper_byte_oe, mem_pins_oe, local_device_claim_oe}, 3'b111);
    endtask : t_float
    task t_sync;
        wr(8'h61, 8'h0E);
        repeat (2) @(negedge clk) chk("sync", {vsync_out, hsync_out}, 2'b10);
        wr(8'h61, 8'h60);
        repeat (2) @(negedge clk) chk("pseq", {vsync_out, hsync_out}, 2'b11);
        standby_mode = 1;
        repeat (2) @(negedge clk) chk("standby oe", vsync_oe, 0);
        wr(8'h61, 8'h70);
        repeat (2) @(negedge clk) chk("standby oe", vsync_oe, 1);
    endtask : t_sync
    task t_gp;
        mon_low = 1;
        wr(8'h63, 8'hF7);
        rd(8'h63, 8'h0B);
        chk("gp", gp_pin_out, 3);
        wr(8'h62, 8'hFF);
        rd(8'h62, 8'h0C);
        chk("chan", {display_channel_clock_pin_oe, display_channel_data_pin_oe, display_channel_clock_pin_out, display_channel_data_pin_out}, 4'hD);
    endtask : t_gp
    initial
    begin
        {io_wr, io_rd, dot_clock, mclk_synth, display_enable, alt} = '0;
        {standby_mode, panel_off_mode, suspend_mode, activity_in, mon_low, io_addr, io_wdata} = '0;
        {rst, vclk_synth, y_enable, pseq_clock} = 4'hF;
        t_straps(0, 8'h57, 8'hB5);
        t_video();
        t_float();
        t_sync();
        t_gp();
        t_straps(1, 8'hA9, 8'h4A);
        summarize();
    end
endmodule : video_pin_and_strap_control_test
bind video_pin_and_strap_control video_pin_props video_pin_props_inst (.clk, .rst, .io_rd, .io_rdata, .blank_oe,
    .video_port_clock_oe, .pixel_port_upper_byte_oe, .suspend_mode, .local_device_claim_oe, .use_external_clocks,
    .reference_clock_pin_oe, .config_reg_bits);
